// ### hw/bors_pkg.sv
// brown-out reset sequencer: shared constants, types and register map
// assumes a single 100 MHz clock domain and an AXI4-Lite register bus
package bors_pkg;

  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CYCLES_PER_US = 1000 / CLK_PERIOD_NS;
  localparam int FALLBACK_US = 100; // crystal fallback delay
  localparam int FALLBACK_CYCLES = FALLBACK_US * CYCLES_PER_US;
  localparam int OST_CYCLES = 1024; // oscillator start-up count

  // ==========================================
  // register byte offsets
  localparam logic [7:0] ADDR_CAUSE = 8'h00;
  localparam logic [7:0] ADDR_OSC = 8'h04;
  localparam logic [7:0] ADDR_POWER_UP_TIMER = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // ==========================================
  // field positions and reset values
  localparam int CAUSE_BOR_BIT = 1;
  localparam int OSC_SRC_LSB = 0; // bits 2:0 current source
  localparam int OSC_PMODE_LSB = 3; // bits 4:3 primary mode
  localparam int OSC_LOCK_BIT = 5;
  localparam int OSC_CLKEN_BIT = 6;
  localparam int OSC_SLEEP_BIT = 8;
  localparam int OSC_IDLE_BIT = 9;
  localparam int IRQ_BOR_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam logic [15:0] POWER_UP_TIMER_RESET = 16'h0000;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ==========================================
  // clock source encodings
  localparam logic [2:0] OSC_FRC_PLL = 3'h1;
  localparam logic [2:0] OSC_PRI = 3'h2;
  localparam logic [2:0] OSC_PRI_PLL = 3'h3;
  localparam logic [1:0] PMODE_EC = 2'h0;
  localparam logic [1:0] PMODE_XT = 2'h1;
  localparam logic [1:0] PMODE_HS = 2'h2;
  localparam logic [1:0] PMODE_OFF = 2'h3;

  // ==========================================
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================
  // types
  typedef struct packed {
    logic [2:0] osc_select_cfg;
    logic [1:0] primary_osc_mode_cfg;
  } bors_cfg_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HOLD = 2'b01,
    ST_WAIT = 2'b10
  } bors_state_t;

endpackage

// ### hw/bors_sync.sv
// two-flop level synchroniser, one bit per lane
// assumes inputs are asynchronous levels
`timescale 1ns/1ps
module bors_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ### hw/bors_timer.sv
// down-counting delay timer, restarted by a start pulse
// assumes start is a one-cycle pulse on clk
`timescale 1ns/1ps
module bors_timer #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [WIDTH-1:0] load,
  output logic busy,
  output logic done
);

  logic [WIDTH-1:0] count_reg;

  // count down; done stays high until the next start
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (start)
    begin
      count_reg <= load;
      busy <= 1'b1;
      done <= 1'b0;
    end
    else if (busy)
    begin
      if (count_reg == '0)
      begin
        busy <= 1'b0;
        done <= 1'b1;
      end
      else
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule

// ### hw/bors_top.sv
// brown-out reset sequencer with AXI4-Lite registers
// assumes brownout_detect and pll_lock are asynchronous levels and the
// configuration fields are static levels on clk
//
// Function
// - a brown-out indication puts the whole device into reset
// - after brown-out, clock source follows oscillator select and primary mode
// - oscillator modes start the oscillator start-up timer on recovery
// - system clock stays gated until the start-up timer expires
// - with the PLL in use, clock stays gated until PLL lock reads one
// - power-up delay runs alongside; internal reset holds until it ends
// - zero power-up delay with a crystal uses the fallback delay instead
// - brown-out sets bit 1 of the reset cause register
// - brown-out detection and reset stay active in sleep and idle
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module bors_top #(
  parameter int ADDR_W = 8,
  parameter int OST_CYCLES = bors_pkg::OST_CYCLES,
  parameter int FALLBACK_CYCLES = bors_pkg::FALLBACK_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic brownout_detect,
  input wire logic pll_lock,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire bors_pkg::bors_cfg_t cfg_in,
  output logic device_reset,
  output logic sys_clk_en,
  output logic irq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ==========================================
  // decoding helpers
  function automatic logic is_osc(input bors_pkg::bors_cfg_t c);
    is_osc = (c.osc_select_cfg == bors_pkg::OSC_PRI ||
              c.osc_select_cfg == bors_pkg::OSC_PRI_PLL) &&
             c.primary_osc_mode_cfg != bors_pkg::PMODE_OFF;
  endfunction

  function automatic logic uses_pll(input bors_pkg::bors_cfg_t c);
    uses_pll = c.osc_select_cfg == bors_pkg::OSC_FRC_PLL ||
               c.osc_select_cfg == bors_pkg::OSC_PRI_PLL;
  endfunction

  function automatic logic is_crystal(input bors_pkg::bors_cfg_t c);
    is_crystal = is_osc(c) &&
                 (c.primary_osc_mode_cfg == bors_pkg::PMODE_XT ||
                  c.primary_osc_mode_cfg == bors_pkg::PMODE_HS);
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // ==========================================
  // synchronised inputs
  logic bo_s;
  logic lock_s;

  bors_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({brownout_detect, pll_lock}),
    .sync_out({bo_s, lock_s})
  );

  // ==========================================
  // sequencer state
  bors_pkg::bors_state_t state_reg;
  bors_pkg::bors_state_t state_next;
  bors_pkg::bors_cfg_t src_reg;
  logic osc_mode_reg;
  logic pll_used_reg;
  logic bo_prev_reg;
  logic [15:0] power_up_timer_reg;
  logic seq_start;
  logic use_fallback;
  logic [31:0] delay_load;
  logic ost_busy;
  logic ost_done;
  logic dly_busy;
  logic dly_done;
  logic clk_ok;
  logic release_now;
  logic bor_rise;
  logic done_event;

  // restart only once the indication is gone
  assign seq_start = state_reg == bors_pkg::ST_HOLD && !bo_s;
  assign use_fallback = power_up_timer_reg == 16'h0000 && is_crystal(cfg_in);
  // fallback replaces the power-up delay entirely
  assign delay_load = use_fallback ? 32'(FALLBACK_CYCLES) :
                      32'(power_up_timer_reg) * 32'(bors_pkg::CYCLES_PER_US);
  // clock held for start-up timer and PLL lock
  assign clk_ok = (!osc_mode_reg || ost_done) &&
                  (!pll_used_reg || lock_s);
  assign release_now = clk_ok && dly_done;
  assign bor_rise = bo_s && !bo_prev_reg;
  assign done_event = state_reg == bors_pkg::ST_WAIT &&
                      state_next == bors_pkg::ST_RUN;

  // oscillator start-up timer, only for oscillator modes
  bors_timer #(
    .WIDTH(32)
  ) u_ost (
    .clk(clk),
    .reset(reset),
    .start(seq_start && is_osc(cfg_in)),
    .load(32'(OST_CYCLES)),
    .busy(ost_busy),
    .done(ost_done)
  );

  // power-up or fallback delay, concurrent with clock start-up
  bors_timer #(
    .WIDTH(32)
  ) u_delay (
    .clk(clk),
    .reset(reset),
    .start(seq_start),
    .load(delay_load),
    .busy(dly_busy),
    .done(dly_done)
  );

  // next state; brown-out wins in every state, sleep and idle included
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      bors_pkg::ST_RUN:
        if (bo_s)
          state_next = bors_pkg::ST_HOLD;
      bors_pkg::ST_HOLD:
        if (!bo_s)
          state_next = bors_pkg::ST_WAIT;
      bors_pkg::ST_WAIT:
        if (bo_s)
          state_next = bors_pkg::ST_HOLD;
        else if (release_now)
          state_next = bors_pkg::ST_RUN;
      default:
        state_next = bors_pkg::ST_HOLD;
    endcase
  end

  // state, reset and clock gate outputs
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= bors_pkg::ST_HOLD;
      device_reset <= 1'b1;
      sys_clk_en <= 1'b0;
      bo_prev_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      device_reset <= state_next != bors_pkg::ST_RUN;
      sys_clk_en <= state_next == bors_pkg::ST_RUN ||
                    (state_next == bors_pkg::ST_WAIT && !seq_start &&
                     clk_ok);
      bo_prev_reg <= bo_s;
    end
  end

  // latch the clock source chosen for this recovery
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      src_reg <= '0;
      osc_mode_reg <= 1'b0;
      pll_used_reg <= 1'b0;
    end
    else if (seq_start)
    begin
      src_reg <= cfg_in;
      osc_mode_reg <= is_osc(cfg_in);
      pll_used_reg <= uses_pll(cfg_in);
    end
  end

  // ==========================================
  // bus slave
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic wr_cause;
  logic wr_power_up_timer;
  logic wr_stat;
  logic wr_mask;
  logic wr_known;
  logic cause_bor_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic [31:0] rd_word;
  logic rd_known;

  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign wmask = lane_mask(wstrb_reg);
  assign wbits = wdata_reg & wmask;

  // write address decode
  always_comb
  begin
    wr_cause = 1'b0;
    wr_power_up_timer = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    wr_known = 1'b1;
    if (awaddr_reg == ADDR_W'(bors_pkg::ADDR_CAUSE))
      wr_cause = do_write;
    else if (awaddr_reg == ADDR_W'(bors_pkg::ADDR_POWER_UP_TIMER))
      wr_power_up_timer = do_write;
    else if (awaddr_reg == ADDR_W'(bors_pkg::ADDR_IRQ_STAT))
      wr_stat = do_write;
    else if (awaddr_reg == ADDR_W'(bors_pkg::ADDR_IRQ_MASK))
      wr_mask = do_write;
    else if (awaddr_reg != ADDR_W'(bors_pkg::ADDR_OSC))
      wr_known = 1'b0;
  end

  // write channels taken in either order, answered when both held
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bors_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? bors_pkg::RESP_OKAY :
                       bors_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // writable control registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      power_up_timer_reg <= bors_pkg::POWER_UP_TIMER_RESET;
      irq_mask_reg <= bors_pkg::IRQ_RESET;
    end
    else
    begin
      if (wr_power_up_timer)
        power_up_timer_reg <= (power_up_timer_reg & ~wmask[15:0]) | wbits[15:0];
      if (wr_mask)
        irq_mask_reg <= (irq_mask_reg & ~wmask[1:0]) | wbits[1:0];
    end
  end

  // sticky flags: set beats a write-one clear
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cause_bor_reg <= 1'b0;
      irq_stat_reg <= bors_pkg::IRQ_RESET;
    end
    else
    begin
      cause_bor_reg <= (cause_bor_reg &
                        !(wr_cause && wbits[bors_pkg::CAUSE_BOR_BIT])) |
                       bor_rise;
      irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? wbits[1:0] : 2'h0)) |
                      {done_event, bor_rise};
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // read address decode
  always_comb
  begin
    rd_word = 32'h00000000;
    rd_known = 1'b1;
    if (s_axi_araddr == ADDR_W'(bors_pkg::ADDR_CAUSE))
      rd_word[bors_pkg::CAUSE_BOR_BIT] = cause_bor_reg;
    else if (s_axi_araddr == ADDR_W'(bors_pkg::ADDR_OSC))
    begin
      rd_word[bors_pkg::OSC_SRC_LSB +: 3] = src_reg.osc_select_cfg;
      rd_word[bors_pkg::OSC_PMODE_LSB +: 2] = src_reg.primary_osc_mode_cfg;
      rd_word[bors_pkg::OSC_LOCK_BIT] = lock_s;
      rd_word[bors_pkg::OSC_CLKEN_BIT] = sys_clk_en;
      rd_word[bors_pkg::OSC_SLEEP_BIT] = sleep_mode;
      rd_word[bors_pkg::OSC_IDLE_BIT] = idle_mode;
    end
    else if (s_axi_araddr == ADDR_W'(bors_pkg::ADDR_POWER_UP_TIMER))
      rd_word[15:0] = power_up_timer_reg;
    else if (s_axi_araddr == ADDR_W'(bors_pkg::ADDR_IRQ_STAT))
      rd_word[1:0] = irq_stat_reg;
    else if (s_axi_araddr == ADDR_W'(bors_pkg::ADDR_IRQ_MASK))
      rd_word[1:0] = irq_mask_reg;
    else
      rd_known = 1'b0;
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= bors_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_known ? bors_pkg::RESP_OKAY : bors_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================
  // checks
  property p_bor_reset;
    bo_s |=> device_reset && !sys_clk_en;
  endproperty
  a_bor_reset: assert property (p_bor_reset)
    else $error("brown-out did not reset device");

  property p_src_latch;
    seq_start |=> src_reg == $past(cfg_in);
  endproperty
  a_src_latch: assert property (p_src_latch)
    else $error("clock source not taken from configuration");

  property p_ost_start;
    (seq_start && is_osc(cfg_in)) |=> ost_busy && !ost_done;
  endproperty
  a_ost_start: assert property (p_ost_start)
    else $error("start-up timer not started");

  property p_clk_gate_ost;
    (sys_clk_en && osc_mode_reg) |-> $past(ost_done);
  endproperty
  a_clk_gate_ost: assert property (p_clk_gate_ost)
    else $error("clock ungated before start-up timer end");

  property p_clk_gate_pll;
    (sys_clk_en && pll_used_reg) |-> $past(lock_s);
  endproperty
  a_clk_gate_pll: assert property (p_clk_gate_pll)
    else $error("clock ungated before PLL lock");

  sequence s_release;
    device_reset ##1 !device_reset;
  endsequence
  property p_power_up_timer_hold;
    s_release |-> $past(dly_done) && !dly_busy;
  endproperty
  a_power_up_timer_hold: assert property (p_power_up_timer_hold)
    else $error("reset released before power-up delay");

  property p_fallback;
    (seq_start && power_up_timer_reg == 16'h0000 && is_crystal(cfg_in)) |->
      delay_load == 32'(FALLBACK_CYCLES);
  endproperty
  a_fallback: assert property (p_fallback)
    else $error("fallback delay not applied");

  property p_flag_set;
    bor_rise |=> cause_bor_reg;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("brown-out flag not set");

  property p_sleep_reset;
    (bo_s && (sleep_mode || idle_mode)) |=> device_reset;
  endproperty
  a_sleep_reset: assert property (p_sleep_reset)
    else $error("brown-out ignored in sleep or idle");

  property p_flag_keep;
    $fell(cause_bor_reg) |-> $past(wr_cause) &&
      $past(wbits[bors_pkg::CAUSE_BOR_BIT]);
  endproperty
  a_flag_keep: assert property (p_flag_keep)
    else $error("brown-out flag lost without clear");

  sequence s_bo_held;
    bo_s ##1 bo_s;
  endsequence
  property p_hold_while_bo;
    s_bo_held |-> device_reset && state_reg == bors_pkg::ST_HOLD &&
      !seq_start;
  endproperty
  a_hold_while_bo: assert property (p_hold_while_bo)
    else $error("sequence started while brown-out persists");

endmodule

// ### dv/bors_far_model.sv
// far-side model: supply monitor and pll feeding the sequencer
// assumes bo_req and lock_dly are driven by the bench on clk
`timescale 1ns/1ps
module bors_far_model (
  input wire logic clk,
  input wire logic bo_req,
  input wire logic [15:0] lock_dly,
  output logic brownout_detect,
  output logic pll_lock
);
  int cnt = 0;
  initial pll_lock = 1'b0;
  // supply monitor level follows the bench request
  assign brownout_detect = bo_req;
  // pll loses lock in brown-out, relocks lock_dly cycles after
  // and then stays locked until the next brown-out
  always @(posedge clk)
  begin
    if (bo_req)
    begin
      cnt <= 0;
      pll_lock <= 1'b0;
    end
    else
    begin
      if (cnt < lock_dly)
        cnt <= cnt + 1;
      pll_lock <= pll_lock || (cnt >= lock_dly);
    end
  end
endmodule

// ### dv/tb_top.sv
// self-checking bench for the brown-out reset sequencer
// assumes bors_pkg, the design files and bors_far_model compiled first
`timescale 1ns/1ps
module tb_top;
  localparam int OSTC = 8;
  localparam int FBC = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic bo_req = 1'b0;
  logic [15:0] lock_dly = 16'h0000;
  logic sleep_mode = 1'b0;
  logic idle_mode = 1'b0;
  bors_pkg::bors_cfg_t cfg_in = '0;
  logic brownout_detect, pll_lock, device_reset, sys_clk_en, irq;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0;
  int comparisons = 0;
  int seed;
  int n;
  logic [2:0] sel_t [5] = '{3'h2, 3'h3, 3'h1, 3'h0, 3'h2};
  logic [1:0] mode_t [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
  int lk_t [5] = '{0, 150, 450, 0, 0};

  // clock generation
  always #5 clk = ~clk;

  bors_far_model far (.clk(clk), .bo_req(bo_req), .lock_dly(lock_dly),
    .brownout_detect(brownout_detect), .pll_lock(pll_lock));

  bors_top #(.OST_CYCLES(OSTC), .FALLBACK_CYCLES(FBC)) dut (
    .clk(clk), .reset(reset), .brownout_detect(brownout_detect),
    .pll_lock(pll_lock), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
    .cfg_in(cfg_in), .device_reset(device_reset), .sys_clk_en(sys_clk_en),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ==========================================
  // verdict and comparisons
  task automatic wrap_up;
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic hang(input string nm);
    error_cnt++;
    $display("unexpected %s: expected finish seen timeout", nm);
    wrap_up();
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic chk_range(input string nm, input int lo, input int hi,
      input int g);
    comparisons++;
    if (g < lo || g > hi)
    begin
      error_cnt++;
      $display("unexpected %s: expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // ==========================================
  // register bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] re);
    int k;
    logic awh, wh, bh;
    logic [1:0] r;
    bh = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50 && !bh; k++)
    begin
      @(negedge clk);
      awh = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      r = bresp;
      @(posedge clk);
      if (awh) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
    if (!bh) hang("write");
    chk_word("bresp", {30'h0, re}, {30'h0, r});
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
      input logic [31:0] e, input logic [1:0] re);
    int k;
    logic arh, rh;
    logic [31:0] d;
    logic [1:0] r;
    rh = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50 && !rh; k++)
    begin
      @(negedge clk);
      arh = arvalid && arready;
      rh = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (arh) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end
    if (!rh) hang("read");
    chk_word(nm, e, d);
    chk_word("rresp", {30'h0, re}, {30'h0, r});
  endtask

  // ==========================================
  // expectations and sequencer scenarios
  function automatic logic osc_of(input logic [2:0] s, input logic [1:0] m);
    return (s == bors_pkg::OSC_PRI || s == bors_pkg::OSC_PRI_PLL)
      && m != bors_pkg::PMODE_OFF;
  endfunction

  function automatic logic pll_of(input logic [2:0] s);
    return s == bors_pkg::OSC_FRC_PLL || s == bors_pkg::OSC_PRI_PLL;
  endfunction

  function automatic int exp_rel(input logic [2:0] s, input logic [1:0] m,
      input int us, input int lk);
    int e;
    e = us * bors_pkg::CYCLES_PER_US;
    if (us == 0 && (m == bors_pkg::PMODE_XT || m == bors_pkg::PMODE_HS))
      e = FBC;
    if (osc_of(s, m) && e < OSTC)
      e = OSTC;
    if (pll_of(s) && e < lk)
      e = lk;
    return e;
  endfunction

  // count cycles to release, checking the clock gate at two points
  task automatic wait_rel(output int c, input int ga, input int gb);
    c = 0;
    while (device_reset === 1'b1 && c < 3000)
    begin
      @(negedge clk);
      c++;
      if (c == ga || c == gb)
        chk_bit("clk_gate", 1'b0, sys_clk_en);
    end
    if (c >= 3000) hang("release");
  endtask

  task automatic run_bo(input int i);
    logic [2:0] s;
    logic [1:0] m;
    int us, lk, ex, c;
    s = sel_t[i];
    m = mode_t[i];
    lk = lk_t[i];
    us = (i == 0) ? 0 : 1 + ($random(seed) & 3);
    ex = exp_rel(s, m, us, lk);
    wr(bors_pkg::ADDR_POWER_UP_TIMER, us, bors_pkg::RESP_OKAY);
    rd_chk("power_up_timer", bors_pkg::ADDR_POWER_UP_TIMER, us, bors_pkg::RESP_OKAY);
    wr(bors_pkg::ADDR_IRQ_MASK, (i == 4) ? 0 : 3, bors_pkg::RESP_OKAY);
    cfg_in <= {s, m};
    lock_dly <= 16'(lk);
    sleep_mode <= (i == 2);
    idle_mode <= (i == 3);
    @(posedge clk);
    bo_req <= 1'b1;
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk_bit("reset_in_bo", 1'b1, device_reset);
    chk_bit("clk_in_bo", 1'b0, sys_clk_en);
    @(posedge clk);
    bo_req <= 1'b0;
    if (i == 1)
    begin
      repeat (6) @(posedge clk);
      bo_req <= 1'b1;
      repeat (5) @(posedge clk);
      bo_req <= 1'b0;
    end
    wait_rel(c, osc_of(s, m) ? OSTC - 1 : -1, pll_of(s) ? lk - 1 : -1);
    chk_range("release_cycles", ex, ex + 14, c);
    chk_bit("clk_at_release", 1'b1, sys_clk_en);
    chk_bit("irq_on", i != 4, irq);
    rd_chk("cause", bors_pkg::ADDR_CAUSE, 32'h2, bors_pkg::RESP_OKAY);
    rd_chk("osc", bors_pkg::ADDR_OSC, {22'h0, i == 3, i == 2, 3'h3, m, s},
      bors_pkg::RESP_OKAY);
    rd_chk("irq_stat", bors_pkg::ADDR_IRQ_STAT, 32'h3, bors_pkg::RESP_OKAY);
    wr(bors_pkg::ADDR_IRQ_STAT, 32'h3, bors_pkg::RESP_OKAY);
    @(negedge clk);
    chk_bit("irq_off", 1'b0, irq);
    rd_chk("cause_kept", bors_pkg::ADDR_CAUSE, 32'h2,
      bors_pkg::RESP_OKAY);
    wr(bors_pkg::ADDR_CAUSE, 32'h2, bors_pkg::RESP_OKAY);
    rd_chk("cause_clr", bors_pkg::ADDR_CAUSE, 32'h0,
      bors_pkg::RESP_OKAY);
  endtask

  // main sequence: reset, register checks, brown-out cases
  initial
  begin
    seed = 32'hFBA3;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    wait_rel(n, -1, -1);
    rd_chk("cause_rst", bors_pkg::ADDR_CAUSE, 32'h0,
      bors_pkg::RESP_OKAY);
    rd_chk("power_up_timer_rst", bors_pkg::ADDR_POWER_UP_TIMER, 32'h0, bors_pkg::RESP_OKAY);
    rd_chk("mask_rst", bors_pkg::ADDR_IRQ_MASK, 32'h0, bors_pkg::RESP_OKAY);
    rd_chk("stat_rst", bors_pkg::ADDR_IRQ_STAT, 32'h2, bors_pkg::RESP_OKAY);
    wr(bors_pkg::ADDR_IRQ_STAT, 32'h2, bors_pkg::RESP_OKAY);
    rd_chk("unmapped", 8'h14, 32'h0, bors_pkg::RESP_SLVERR);
    wr(8'h18, 32'hFFFFFFFF, bors_pkg::RESP_SLVERR);
    wr(bors_pkg::ADDR_OSC, 32'h0, bors_pkg::RESP_OKAY);
    chk_bit("irq_idle", 1'b0, irq);
    for (int i = 0; i < 5; i++)
      run_bo(i);
    wrap_up();
  end
endmodule
